/* File: srm_pkg.sv */
/*
  Shared constants and types for the speed report messaging block:
  register offsets, field positions, reset values, link byte codes
  and the report carrier.
  Assumes a 40 MHz system clock and 8-bit speed values.
*/
`default_nettype none
package srm_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int MSG_PER_SEC = 10;
  localparam int STREAM_CYCLES = CLK_HZ / MSG_PER_SEC;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FORMAT = 8'h04;
  localparam logic [7:0] OFS_TARGET = 8'h08;
  localparam logic [7:0] OFS_UNIT_ADDR = 8'h0C;
  localparam logic [7:0] OFS_THRESH0 = 8'h10;
  localparam logic [7:0] OFS_THRESH3 = 8'h1C;
  localparam logic [7:0] OFS_SPEED_A = 8'h20;
  localparam logic [7:0] OFS_SPEED_B = 8'h24;

  // Control register bit positions
  localparam int CTRL_XMIT_ON = 0;
  localparam int CTRL_HANDSHAKE = 1;
  localparam int CTRL_MULTIDROP = 2;
  localparam int CTRL_LOCK = 3;
  localparam int CTRL_UNLOCK = 4;

  // Reset values
  localparam logic [7:0] THR_LOW_RST = 8'h00;
  localparam logic [7:0] THR_HIGH_RST = 8'hFF;
  localparam logic [7:0] UNIT_ADDR_RST = 8'h02;

  // In multi-drop mode only this unit address answers plain polled-status requests
  localparam logic [7:0] PLAIN_POLL_ADDR = 8'h02;

  // ****************************************************************
  // Link byte codes and frame layout
  // ****************************************************************
  localparam logic [7:0] REQ_POLL = 8'h10;
  localparam logic [7:0] REQ_ADDR_POLL = 8'h11;
  localparam logic [7:0] FRM_START = 8'h02;
  localparam logic [7:0] FRM_TERM = 8'h0D;
  localparam logic [2:0] FRAME_LAST = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    simple_ascii_format,
    simple_ascii_format_alt,
    binary_report_format,
    binary_report_format_ext,
    column_format,
    serial_short_format,
    polled_status_format
  } srm_fmt_t;

  typedef enum logic [1:0] {
    tgt_baseball,
    tgt_carnival,
    tgt_car,
    tgt_tennis
  } srm_tgt_t;

  typedef struct packed {
    logic [7:0] live;
    logic [7:0] peak;
    logic [7:0] hit;
    logic [7:0] locked;
    logic [7:0] highest;
  } srm_speeds_t;

endpackage
`default_nettype wire

/* File: srm_top.sv */
/*
  Speed report messaging block: AXI4-Lite register slave, speed
  capture with per-target thresholds, streaming and polled framing
  onto a byte-wide serial link with a line driver enable.
  Assumes an external UART that takes one byte per valid/ready
  handshake and hands received bytes in as one-cycle strobes.
*/
// Summary of operation
// - Speeds captured only while transmitter is on
// - Polled-status format never streams
// - Stream one message per fixed period
// - Handshake mode: one packet per request
// - Multi-drop unit talks only when asked
// - Multi-drop plain poll answered only at address 2
// - Addressed poll returns configured format once
// - Only matching address replies to addressed poll
// - Report live, peak, hit, locked, highest
// - Carnival produces no hit speed
// - Car mode: live, peak, lock capture
// - Suppress speeds below per-target low threshold
// - Suppress speeds above per-target high threshold
`timescale 1ns/10ps
`default_nettype none
module srm_top
  import srm_pkg::*;
#(
  parameter int STREAM_PERIOD = STREAM_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // AXI4-Lite write channels
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Radar front end
  input wire logic i_spd_valid,
  input wire logic [7:0] i_spd,
  input wire logic i_hit_valid,
  input wire logic [7:0] i_hit_spd,
  input wire logic i_tgt_end,
  output logic o_xmit_on,
  // Serial link, byte level
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  input wire logic i_tx_ready,
  output logic o_line_drive_en
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic in_window(input logic [7:0] s, input logic [7:0] lo,
                                     input logic [7:0] hi);
    in_window = (s >= lo) && (s <= hi);
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction

  // Byte lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // Frame: start, format, live, peak, hit, locked, highest, terminator
  function automatic logic [7:0] frame_byte(input logic [2:0] idx, input srm_fmt_t f,
                                            input srm_speeds_t s);
    case (idx)
      3'h0: frame_byte = FRM_START;
      3'h1: frame_byte = {5'h00, f};
      3'h2: frame_byte = s.live;
      3'h3: frame_byte = s.peak;
      3'h4: frame_byte = s.hit;
      3'h5: frame_byte = s.locked;
      3'h6: frame_byte = s.highest;
      default: frame_byte = FRM_TERM;
    endcase
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic xmit_on;
  logic handshake;
  logic multidrop;
  logic lock_pulse;
  logic unlock_pulse;
  srm_fmt_t fmt;
  srm_tgt_t tgt;
  logic [7:0] unit_addr;
  logic [7:0] thr_lo [4];
  logic [7:0] thr_hi [4];
  srm_speeds_t spd;

  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] cur_word;
  logic cur_ok;
  logic hit_ok;

  assign do_write = aw_hold && w_hold && !o_s_axi_bvalid;

  // Read-back word for a given address, also the base for partial writes
  function automatic logic [31:0] read_word(input logic [7:0] a, output logic ok);
    ok = 1'b1;
    read_word = 32'h0000_0000;
    if (a == OFS_CTRL) begin
      read_word = {29'h0000_0000, multidrop, handshake, xmit_on};
    end else if (a == OFS_FORMAT) begin
      read_word = {29'h0000_0000, fmt};
    end else if (a == OFS_TARGET) begin
      read_word = {30'h0000_0000, tgt};
    end else if (a == OFS_UNIT_ADDR) begin
      read_word = {24'h00_0000, unit_addr};
    end else if (a >= OFS_THRESH0 && a <= OFS_THRESH3 && a[1:0] == 2'b00) begin
      read_word = {16'h0000, thr_hi[a[3:2]], thr_lo[a[3:2]]};
    end else if (a == OFS_SPEED_A) begin
      read_word = {spd.live, spd.peak, spd.hit, spd.locked};
    end else if (a == OFS_SPEED_B) begin
      read_word = {24'h00_0000, spd.highest};
    end else begin
      ok = 1'b0;
    end
  endfunction

  always_comb begin
    cur_ok = 1'b0;
    cur_word = read_word(aw_addr, cur_ok);
  end

  // Write address and data taken in either order, one write in flight
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end else begin
      o_s_axi_awready <= !aw_hold && !(i_s_axi_awvalid && o_s_axi_awready);
      o_s_axi_wready <= !w_hold && !(i_s_axi_wvalid && o_s_axi_wready);
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= cur_ok ? RESP_OKAY : RESP_SLVERR; // Unmapped writes dropped
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xmit_on <= 1'b0;
      handshake <= 1'b0;
      multidrop <= 1'b0;
      lock_pulse <= 1'b0;
      unlock_pulse <= 1'b0;
      fmt <= simple_ascii_format;
      tgt <= tgt_baseball;
      unit_addr <= UNIT_ADDR_RST;
      for (int i = 0; i < 4; i++) begin
        thr_lo[i] <= THR_LOW_RST;
        thr_hi[i] <= THR_HIGH_RST;
      end
    end else begin
      lock_pulse <= 1'b0;
      unlock_pulse <= 1'b0;
      if (do_write) begin
        logic [31:0] m;
        m = merge(cur_word, w_data, w_strb);
        if (aw_addr == OFS_CTRL) begin
          xmit_on <= m[CTRL_XMIT_ON];
          handshake <= m[CTRL_HANDSHAKE];
          multidrop <= m[CTRL_MULTIDROP];
          lock_pulse <= w_strb[0] && w_data[CTRL_LOCK];
          unlock_pulse <= w_strb[0] && w_data[CTRL_UNLOCK];
        end else if (aw_addr == OFS_FORMAT) begin
          // Codes above the last format are ignored
          if (m[2:0] <= 3'(polled_status_format)) begin
            fmt <= srm_fmt_t'(m[2:0]);
          end
        end else if (aw_addr == OFS_TARGET) begin
          tgt <= srm_tgt_t'(m[1:0]);
        end else if (aw_addr == OFS_UNIT_ADDR) begin
          unit_addr <= m[7:0];
        end else if (aw_addr >= OFS_THRESH0 && aw_addr <= OFS_THRESH3 &&
                     aw_addr[1:0] == 2'b00) begin
          thr_lo[aw_addr[3:2]] <= m[7:0];
          thr_hi[aw_addr[3:2]] <= m[15:8];
        end
      end
    end
  end

  // Registered read answer, one cycle after the address is taken
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= RESP_OKAY;
    end else begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        logic ok;
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= read_word(i_s_axi_araddr, ok);
        o_s_axi_rresp <= ok ? RESP_OKAY : RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end else if (!o_s_axi_rvalid) begin
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Speed capture
  // ****************************************************************
  logic spd_ok;
  assign spd_ok = xmit_on && i_spd_valid &&
                  in_window(i_spd, thr_lo[tgt], thr_hi[tgt]);
  assign hit_ok = xmit_on && i_hit_valid && tgt != tgt_carnival &&
                  in_window(i_hit_spd, thr_lo[tgt], thr_hi[tgt]);

  // Peak follows the current target; highest survives until reset
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      spd <= '0;
    end else begin
      if (i_tgt_end) begin
        spd.live <= 8'h00;
        spd.peak <= 8'h00;
      end else if (spd_ok) begin
        spd.live <= i_spd;
        spd.peak <= max8(spd.peak, i_spd);
      end
      if (spd_ok) begin
        spd.highest <= max8(spd.highest, i_spd);
      end
      if (tgt == tgt_carnival) begin
        spd.hit <= 8'h00;
      end else if (hit_ok) begin
        spd.hit <= i_hit_spd;
      end
      if (lock_pulse && tgt == tgt_car) begin
        spd.locked <= spd.live;
      end else if (unlock_pulse) begin
        spd.locked <= 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_xmit_on <= 1'b0;
    end else begin
      o_xmit_on <= xmit_on;
    end
  end

  // ****************************************************************
  // Stream timer
  // ****************************************************************
  logic [31:0] stream_cnt;
  logic stream_en;
  logic stream_tick;
  assign stream_en = xmit_on && !multidrop && !handshake &&
                     fmt != polled_status_format;
  assign stream_tick = stream_en && stream_cnt == 32'(STREAM_PERIOD - 1);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stream_cnt <= 32'h0000_0000;
    end else if (!stream_en || stream_tick) begin
      stream_cnt <= 32'h0000_0000;
    end else begin
      stream_cnt <= stream_cnt + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Request parser
  // ****************************************************************
  typedef enum logic {rx_idle, rx_addr} srm_rx_t;
  srm_rx_t rx_state;
  logic poll_req;
  logic addr_req;

  // Plain polls: handshake mode, or multi-drop at the fixed address
  assign poll_req = rx_state == rx_idle && i_rx_valid && i_rx_byte == REQ_POLL &&
                    xmit_on && (multidrop ? unit_addr == PLAIN_POLL_ADDR
                                          : handshake);
  assign addr_req = rx_state == rx_addr && i_rx_valid &&
                    multidrop && i_rx_byte == unit_addr;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_state <= rx_idle;
    end else begin
      case (rx_state)
        rx_idle: begin
          if (i_rx_valid && i_rx_byte == REQ_ADDR_POLL && multidrop) begin
            rx_state <= rx_addr;
          end
        end
        default: begin
          if (i_rx_valid) begin
            rx_state <= rx_idle;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Frame transmitter
  // ****************************************************************
  typedef enum logic {tx_idle, tx_send} srm_tx_t;
  srm_tx_t tx_state;
  logic pend;
  srm_fmt_t pend_fmt;
  srm_fmt_t snap_fmt;
  srm_speeds_t snap_spd;
  logic [2:0] idx;
  logic start;
  assign start = tx_state == tx_idle && pend;

  // A new request in the start cycle stays pending
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend <= 1'b0;
      pend_fmt <= simple_ascii_format;
    end else if (poll_req) begin
      pend <= 1'b1;
      pend_fmt <= polled_status_format;
    end else if (addr_req || stream_tick) begin
      pend <= 1'b1;
      pend_fmt <= fmt;
    end else if (start) begin
      pend <= 1'b0;
    end
  end

  // Driver enabled only for our own reply, never between frames
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state <= tx_idle;
      idx <= 3'h0;
      snap_fmt <= simple_ascii_format;
      snap_spd <= '0;
      o_tx_valid <= 1'b0;
      o_tx_byte <= 8'h00;
      o_line_drive_en <= 1'b0;
    end else begin
      case (tx_state)
        tx_idle: begin
          if (start) begin
            tx_state <= tx_send;
            idx <= 3'h0;
            snap_fmt <= pend_fmt;
            snap_spd <= spd;
            o_tx_valid <= 1'b1;
            o_tx_byte <= frame_byte(3'h0, pend_fmt, spd);
            o_line_drive_en <= 1'b1;
          end
        end
        default: begin
          if (o_tx_valid && i_tx_ready) begin
            if (idx == FRAME_LAST) begin
              tx_state <= tx_idle;
              o_tx_valid <= 1'b0;
              o_line_drive_en <= 1'b0;
            end else begin
              idx <= idx + 3'h1;
              o_tx_byte <= frame_byte(idx + 3'h1, snap_fmt, snap_spd);
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: srm_monitor.sv */
/*
  Checker for srm_top: register bus handshakes and link framing.
  Assumes binding onto srm_top with one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module srm_monitor
  import srm_pkg::*;
#(
  parameter int STREAM_PERIOD = STREAM_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Register bus
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Serial link
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_byte,
  input wire logic i_tx_ready,
  input wire logic o_line_drive_en
);
  // ********
  // Frame byte counter
  // ********
  logic [2:0] byte_idx;

  // Counts taken bytes, since speed data may itself equal the terminator
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      byte_idx <= 3'h0;
    end else if (o_tx_valid && i_tx_ready) begin
      byte_idx <= byte_idx + 3'h1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_write_answer: assert property ( // AXI
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |=> ##1 o_s_axi_bvalid)
    else $error("write response missing");
  a_bresp_held: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
  a_write_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
    else $error("address taken during response");
  a_read_answer: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("read answer late");
  a_rdata_held: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped");
  a_unmapped_read: assert property (
    i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr > 8'h24
    |=> o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answered");
  a_frame_start: assert property (
    $rose(o_tx_valid) |-> o_tx_byte == FRM_START && byte_idx == 3'h0)
    else $error("frame start wrong");
  a_tx_held: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
    else $error("link byte changed");
  a_frame_term: assert property (
    o_tx_valid && i_tx_ready && byte_idx == FRAME_LAST
    |-> (o_tx_byte == FRM_TERM) ##1 (!o_tx_valid && !o_line_drive_en))
    else $error("frame end wrong");
  a_drive_span: assert property (o_tx_valid |-> o_line_drive_en)
    else $error("byte sent with driver off");
endmodule
bind srm_top srm_monitor #(.STREAM_PERIOD(STREAM_PERIOD)) u_srm_monitor (.*);
`default_nettype wire

/* File: srm_link_ctl_model.sv */
/*
  Link controller model: sends request bytes, takes report bytes.
  Assumes the byte-level link of srm_top; stalls while slow is set.
*/
`timescale 1ns/10ps
`default_nettype none
module srm_link_ctl_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Bytes from the sensor
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  output logic o_tx_ready,
  // Bytes to the sensor
  output var logic o_rx_valid,
  output var logic [7:0] o_rx_byte
);
  // ********
  // Receive and request
  // ********
  bit slow = 1'b0;
  logic [7:0] got[$];
  logic [7:0] lfsr;

  // Random stalls while slow is set force the sensor to hold some bytes
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lfsr <= 8'h5a;
      o_tx_ready <= 1'b0;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      o_tx_ready <= !slow || lfsr[0];
    end
  end

  // Keep every byte taken
  always @(posedge i_clk_sys) begin
    if (i_tx_valid && o_tx_ready) begin
      got.push_back(i_tx_byte);
    end
  end

  // Idle line until the first request
  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
  end

  // One-cycle strobe; line then shows the inverse, never a stale byte
  task automatic send(input logic [7:0] b);
    @(posedge i_clk_sys);
    o_rx_valid <= 1'b1;
    o_rx_byte <= b;
    @(posedge i_clk_sys);
    o_rx_valid <= 1'b0;
    o_rx_byte <= ~b;
  endtask
endmodule
`default_nettype wire

/* File: speed_report_messaging_tb.sv */
/*
  Self-checking bench for srm_top: registers, speed capture,
  streaming, handshake polls and multi-drop addressing.
  Assumes srm_pkg, the monitor bind and the link controller model.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module speed_report_messaging_tb;
  import srm_pkg::*;
  // ********
  // Bench signals
  // ********
  localparam int SP = 50;
  logic i_clk_sys, i_rst_n, i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready;
  logic o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic i_s_axi_rready, i_spd_valid, i_hit_valid, i_tgt_end, o_xmit_on, i_rx_valid;
  logic o_tx_valid, i_tx_ready, o_line_drive_en;
  logic [7:0] i_s_axi_awaddr, i_s_axi_araddr, i_spd, i_hit_spd, i_rx_byte, o_tx_byte;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rs;
  logic [7:0] live, peak, hs, v;
  logic [7:0] crn [4] = '{8'h1f, 8'h20, 8'h60, 8'h61};
  int mismatches, cmp_count, seed;
  real t0;

  srm_top #(.STREAM_PERIOD(SP)) DUT (.*);
  srm_link_ctl_model ctl (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_tx_valid(o_tx_valid),
    .i_tx_byte(o_tx_byte), .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid),
    .o_rx_byte(i_rx_byte));

  // 40 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    mismatches++;
    give_verdict();
  end

  function automatic bit in_window(input logic [7:0] s);
    return s >= 8'h20 && s <= 8'h60;
  endfunction

  function automatic logic [7:0] mx(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit pa, pw;
    pa = 1;
    pw = 1;
    @(posedge i_clk_sys);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge i_clk_sys);
      pa = pa && !o_s_axi_awready;
      pw = pw && !o_s_axi_wready;
      if (!pa) i_s_axi_awvalid <= 1'b0;
      if (!pw) i_s_axi_wvalid <= 1'b0;
    end
    while (!o_s_axi_bvalid) @(posedge i_clk_sys);
    rs = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    @(posedge i_clk_sys);
    while (!o_s_axi_arready) @(posedge i_clk_sys);
    i_s_axi_arvalid <= 1'b0;
    @(posedge i_clk_sys);
    while (!o_s_axi_rvalid) @(posedge i_clk_sys);
    rd = o_s_axi_rdata;
    rs = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_reg(a);
    `CHK(rd & m, e & m)
  endtask

  // Kind 0 speed, 1 hit, 2 target gone
  task automatic pulse(input int k, input logic [7:0] s);
    @(posedge i_clk_sys);
    i_spd_valid <= (k == 0);
    i_hit_valid <= (k == 1);
    i_tgt_end <= (k == 2);
    i_spd <= s;
    i_hit_spd <= s;
    @(posedge i_clk_sys);
    {i_spd_valid, i_hit_valid, i_tgt_end} <= 3'h0;
  endtask

  task automatic idle_clear();
    @(posedge i_clk_sys);
    while (o_tx_valid) @(posedge i_clk_sys);
    ctl.got.delete();
  endtask

  task automatic next_start();
    while (o_tx_valid) @(posedge i_clk_sys);
    while (!o_tx_valid) @(posedge i_clk_sys);
  endtask

  task automatic frame(input logic [7:0] f);
    repeat (4 * SP) begin
      if (ctl.got.size() < 8) @(posedge i_clk_sys);
    end
    `CHK(ctl.got.size(), 8)
    `CHK(ctl.got[0], FRM_START)
    `CHK(ctl.got[1], f)
    `CHK(ctl.got[6], mx(hs, 8'h70))
    `CHK(ctl.got[7], FRM_TERM)
    ctl.got.delete();
  endtask

  task automatic quiet(input int k);
    repeat (k) @(posedge i_clk_sys);
    `CHK(ctl.got.size(), 0)
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ********
  // Test sequence
  // ********
  initial begin
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = 4'h0;
    {i_s_axi_rready, i_spd_valid, i_hit_valid, i_tgt_end} = 4'h0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_spd, i_hit_spd, i_s_axi_wdata} = '0;
    i_s_axi_wstrb = 4'hf;
    {mismatches, cmp_count, live, peak, hs} = '0;
    seed = 7;
    i_rst_n = 1'b0;
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    rdc(OFS_UNIT_ADDR, 32'h0000_0002, '1);
    rdc(OFS_THRESH3, 32'h0000_ff00, '1);
    rd_reg(8'h28);
    `CHK(rs, RESP_SLVERR)
    wr(8'h30, 32'h0000_0001);
    `CHK(rs, RESP_SLVERR)
    $display("test registers done");
    pulse(0, 8'h30);
    rdc(OFS_SPEED_A, 32'h0000_0000, '1);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_THRESH0, 32'h0000_6020);
    `CHK(o_xmit_on, 1'b1)
    // Window edges first, then random samples
    for (int i = 0; i < 28; i++) begin
      v = (i < 4) ? crn[i] : 8'($random(seed));
      pulse(0, v);
      live = in_window(v) ? v : live;
      peak = in_window(v) ? mx(peak, v) : peak;
      hs = in_window(v) ? mx(hs, v) : hs;
    end
    rdc(OFS_SPEED_A, {live, peak, 16'h0000}, '1);
    rdc(OFS_SPEED_B, {24'h00_0000, hs}, '1);
    pulse(1, 8'h40);
    rdc(OFS_SPEED_A, 32'h0000_4000, 32'h0000_ff00);
    $display("test capture done");
    wr(OFS_TARGET, 32'h0000_0001);
    pulse(2, 8'h00);
    pulse(1, 8'h44);
    pulse(0, 8'h45);
    rdc(OFS_SPEED_A, 32'h4545_0000, 32'hffff_ff00);
    wr(OFS_TARGET, 32'h0000_0002);
    pulse(2, 8'h00);
    pulse(0, 8'h70);
    wr(OFS_CTRL, 32'h0000_0009);
    rdc(OFS_SPEED_A, 32'h7070_0070, 32'hffff_00ff);
    wr(OFS_CTRL, 32'h0000_0011);
    rdc(OFS_SPEED_A, 32'h0000_0000, 32'h0000_00ff);
    rdc(OFS_SPEED_B, {24'h00_0000, mx(hs, 8'h70)}, '1);
    $display("test targets done");
    wr(OFS_FORMAT, 32'h0000_0003);
    next_start();
    t0 = $realtime;
    next_start();
    `CHK(int'(($realtime - t0) / 25.0), SP)
    for (int f = 0; f < 6; f++) begin
      wr(OFS_FORMAT, 32'(f));
      idle_clear();
      frame(8'(f));
    end
    wr(OFS_FORMAT, 32'h0000_0006);
    idle_clear();
    quiet(3 * SP);
    $display("test stream done");
    wr(OFS_CTRL, 32'h0000_0003);
    idle_clear();
    quiet(2 * SP);
    ctl.slow = 1'b1;
    repeat (3) begin
      ctl.send(REQ_POLL);
      frame(8'h06);
    end
    quiet(SP);
    $display("test handshake done");
    wr(OFS_FORMAT, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0005);
    idle_clear();
    quiet(2 * SP);
    ctl.send(REQ_POLL);
    frame(8'h06);
    wr(OFS_UNIT_ADDR, 32'h0000_0005);
    ctl.send(REQ_POLL);
    quiet(SP);
    for (int f = 2; f < 6; f += 3) begin
      wr(OFS_FORMAT, 32'(f));
      ctl.send(REQ_ADDR_POLL);
      ctl.send(8'h05);
      frame(8'(f));
    end
    ctl.send(REQ_ADDR_POLL);
    ctl.send(8'h07);
    quiet(SP);
    `CHK(o_line_drive_en, 1'b0)
    $display("test multidrop done");
    give_verdict();
  end
endmodule
`default_nettype wire
